// file: include/dpt_pkg.sv
// Constants, carriers and helpers for the DSCP priority slice and table access bank.
// Assumes 16-bit banked registers reached by a 4-bit offset plus a bank select at 0xE.
package dpt_pkg;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned OFF_W  = 4;
	localparam int unsigned BANK_W = 6;
	localparam int unsigned TD_W   = 67;
	localparam int unsigned TA_W   = 10;

	localparam logic [BANK_W-1:0] BANK_PRIO_A = 6'h28;
	localparam logic [BANK_W-1:0] BANK_PRIO_B = 6'h29;
	localparam logic [BANK_W-1:0] BANK_TABLE  = 6'h2a;
	localparam logic [BANK_W-1:0] BANK_RSVD   = 6'h2b;
	localparam logic [BANK_W-1:0] BANK_TEST   = 6'h2c;
	localparam logic [BANK_W-1:0] BANK_RST    = 6'h00;

	localparam logic [OFF_W-1:0] OFF_MAP6      = 4'ha;
	localparam logic [OFF_W-1:0] OFF_MAP7      = 4'h0;
	localparam logic [OFF_W-1:0] OFF_MAP8      = 4'h2;
	localparam logic [OFF_W-1:0] OFF_TAC       = 4'h0;
	localparam logic [OFF_W-1:0] OFF_TD_TOP    = 4'h2;
	localparam logic [OFF_W-1:0] OFF_TD_47     = 4'h4;
	localparam logic [OFF_W-1:0] OFF_TD_63     = 4'h6;
	localparam logic [OFF_W-1:0] OFF_TD_15     = 4'h8;
	localparam logic [OFF_W-1:0] OFF_TD_31     = 4'ha;
	localparam logic [OFF_W-1:0] OFF_DTS       = 4'h0;
	localparam logic [OFF_W-1:0] OFF_ATS       = 4'h2;
	localparam logic [OFF_W-1:0] OFF_DTC       = 4'h4;
	localparam logic [OFF_W-1:0] OFF_ATC_LED   = 4'h6;
	localparam logic [OFF_W-1:0] OFF_ATC_SPARE = 4'h8;
	localparam logic [OFF_W-1:0] OFF_BANK_SEL  = 4'he;

	localparam int unsigned TAC_DIR_BIT  = 12;
	localparam int unsigned TAC_SEL_LSB  = 10;
	localparam int unsigned TD_BUSY_BIT  = 7;
	localparam int unsigned LED_LSB      = 6;
	localparam logic [5:0]  PRIO_BASE_IDX = 6'h28;

	localparam logic [DATA_W-1:0] MAP_RST       = 16'h0000;
	localparam logic [DATA_W-1:0] TAC_RST       = 16'h0000;
	localparam logic [TD_W-1:0]   TD_RST        = 67'h0;
	localparam logic [7:0]        DTC_RST       = 8'h3f;
	localparam logic [5:0]        ATC_RSVD_RST  = 6'h00;
	localparam logic [DATA_W-1:0] ATC_SPARE_RST = 16'h0000;

	typedef enum logic [1:0] {
		SEL_STATIC  = 2'h0,
		SEL_VLAN    = 2'h1,
		SEL_DYNAMIC = 2'h2,
		SEL_MIB     = 2'h3
	} dpt_sel_e;

	typedef enum logic [1:0] {
		LED_60MA = 2'h0,
		LED_80MA = 2'h1,
		LED_97MA = 2'h2,
		LED_40MA = 2'h3
	} dpt_led_e;

	typedef enum logic [1:0] {
		TS_IDLE = 2'b01,
		TS_WAIT = 2'b10
	} dpt_tstate_e;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [OFF_W-1:0]  addr;
		logic [DATA_W-1:0] wdata;
	} dpt_bus_s;

	typedef struct packed {
		logic       valid;
		logic [7:0] tos;
	} dpt_pkt_s;

	typedef struct packed {
		logic       valid;
		logic       hit;
		logic [1:0] prio;
	} dpt_prio_s;

	typedef struct packed {
		logic            valid;
		logic            rd;
		dpt_sel_e        sel;
		logic [TA_W-1:0] addr;
		logic [TD_W-1:0] wdata;
	} dpt_cmd_s;

	typedef struct packed {
		logic            done;
		logic [TD_W-1:0] rdata;
	} dpt_rsp_s;

	function automatic logic [1:0] dpt_field(input logic [DATA_W-1:0] map, input logic [2:0] idx);
		return map[{idx, 1'b0} +: 2];
	endfunction

	function automatic logic dpt_polled(input logic [1:0] sel);
		return sel == SEL_DYNAMIC || sel == SEL_MIB;
	endfunction
endpackage

// file: rtl/dpt_regs.sv
// Banked register slice: upper DSCP priority maps, indirect table access, test bank.
// Assumes one 10 MHz clock, a strobe register port and an external table engine.
//
// Added by the designer: the address-and-strobe port.
module dpt_regs
	import dpt_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire dpt_bus_s    reg_bus,
	output logic [DATA_W-1:0] reg_rdata_ff,
	input  wire dpt_pkt_s    pkt_in,
	output dpt_prio_s        prio_ff,
	output dpt_cmd_s         tbl_cmd_ff,
	input  wire dpt_rsp_s    tbl_rsp,
	output dpt_led_e         led_current_ff
);

	logic [BANK_W-1:0] bank_ff;
	logic [BANK_W-1:0] nxt_bank;
	logic [DATA_W-1:0] map6_ff;
	logic [DATA_W-1:0] map7_ff;
	logic [DATA_W-1:0] map8_ff;
	logic [DATA_W-1:0] nxt_map6;
	logic [DATA_W-1:0] nxt_map7;
	logic [DATA_W-1:0] nxt_map8;
	logic [DATA_W-1:0] tac_ff;
	logic [DATA_W-1:0] nxt_tac;
	logic [7:0]        dtc_ff;
	logic [7:0]        nxt_dtc;
	logic [5:0]        atc_rsvd_ff;
	logic [5:0]        nxt_atc_rsvd;
	logic [DATA_W-1:0] atc_spare_ff;
	logic [DATA_W-1:0] nxt_atc_spare;
	dpt_led_e          nxt_led;
	logic [TD_W-1:0]   tdata_ff;
	logic [TD_W-1:0]   nxt_tdata;
	dpt_tstate_e       tstate_ff;
	dpt_tstate_e       nxt_tstate;
	dpt_cmd_s          nxt_cmd;
	dpt_prio_s         nxt_prio;
	logic [DATA_W-1:0] nxt_rdata;
	logic              busy;
	logic              wr_bsel;
	logic              wr_map6;
	logic              wr_map7;
	logic              wr_map8;
	logic              wr_tac;
	logic              wr_td47;
	logic              wr_td63;
	logic              wr_td15;
	logic              wr_td31;
	logic              wr_dtc;
	logic              wr_atc_led;
	logic              wr_atc_spare;
	logic [5:0]        tos_idx;

	// Write decode; the bank select answers in every bank
	always_comb begin
		wr_bsel      = reg_bus.wr && reg_bus.addr == OFF_BANK_SEL;
		wr_map6      = reg_bus.wr && bank_ff == BANK_PRIO_A && reg_bus.addr == OFF_MAP6;
		wr_map7      = reg_bus.wr && bank_ff == BANK_PRIO_B && reg_bus.addr == OFF_MAP7;
		wr_map8      = reg_bus.wr && bank_ff == BANK_PRIO_B && reg_bus.addr == OFF_MAP8;
		wr_tac       = reg_bus.wr && bank_ff == BANK_TABLE && reg_bus.addr == OFF_TAC;
		wr_td47      = reg_bus.wr && bank_ff == BANK_TABLE && reg_bus.addr == OFF_TD_47;
		wr_td63      = reg_bus.wr && bank_ff == BANK_TABLE && reg_bus.addr == OFF_TD_63;
		wr_td15      = reg_bus.wr && bank_ff == BANK_TABLE && reg_bus.addr == OFF_TD_15;
		wr_td31      = reg_bus.wr && bank_ff == BANK_TABLE && reg_bus.addr == OFF_TD_31;
		wr_dtc       = reg_bus.wr && bank_ff == BANK_TEST && reg_bus.addr == OFF_DTC;
		wr_atc_led   = reg_bus.wr && bank_ff == BANK_TEST && reg_bus.addr == OFF_ATC_LED;
		wr_atc_spare = reg_bus.wr && bank_ff == BANK_TEST && reg_bus.addr == OFF_ATC_SPARE;
	end

	// Plain configuration registers
	always_comb begin
		nxt_bank      = bank_ff;
		nxt_map6      = map6_ff;
		nxt_map7      = map7_ff;
		nxt_map8      = map8_ff;
		nxt_tac       = tac_ff;
		nxt_dtc       = dtc_ff;
		nxt_atc_rsvd  = atc_rsvd_ff;
		nxt_atc_spare = atc_spare_ff;
		nxt_led       = led_current_ff;
		if (wr_bsel) begin
			nxt_bank = reg_bus.wdata[BANK_W-1:0];
		end
		if (wr_map6) begin
			nxt_map6 = reg_bus.wdata;
		end
		if (wr_map7) begin
			nxt_map7 = reg_bus.wdata;
		end
		if (wr_map8) begin
			nxt_map8 = reg_bus.wdata;
		end
		if (wr_tac) begin
			nxt_tac = reg_bus.wdata;
		end
		if (wr_dtc) begin
			nxt_dtc = reg_bus.wdata[7:0];
		end
		if (wr_atc_led) begin
			nxt_led      = dpt_led_e'(reg_bus.wdata[LED_LSB +: 2]);
			nxt_atc_rsvd = reg_bus.wdata[5:0];
		end
		if (wr_atc_spare) begin
			nxt_atc_spare = reg_bus.wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			bank_ff        <= BANK_RST;
			map6_ff        <= MAP_RST;
			map7_ff        <= MAP_RST;
			map8_ff        <= MAP_RST;
			tac_ff         <= TAC_RST;
			dtc_ff         <= DTC_RST;
			atc_rsvd_ff    <= ATC_RSVD_RST;
			atc_spare_ff   <= ATC_SPARE_RST;
			led_current_ff <= LED_60MA;
		end else begin
			bank_ff        <= nxt_bank;
			map6_ff        <= nxt_map6;
			map7_ff        <= nxt_map7;
			map8_ff        <= nxt_map8;
			tac_ff         <= nxt_tac;
			dtc_ff         <= nxt_dtc;
			atc_rsvd_ff    <= nxt_atc_rsvd;
			atc_spare_ff   <= nxt_atc_spare;
			led_current_ff <= nxt_led;
		end
	end

	// Busy only means something for tables the engine answers slowly
	assign busy = tstate_ff == TS_WAIT && dpt_polled(tac_ff[TAC_SEL_LSB +: 2]);

	// Table command engine and indirect data word
	always_comb begin
		nxt_tstate    = tstate_ff;
		nxt_tdata     = tdata_ff;
		nxt_cmd       = tbl_cmd_ff;
		nxt_cmd.valid = 1'b0;
		if (wr_td47) begin
			nxt_tdata[47:32] = reg_bus.wdata;
		end
		if (wr_td63) begin
			nxt_tdata[63:48] = reg_bus.wdata;
		end
		if (wr_td15) begin
			nxt_tdata[15:0] = reg_bus.wdata;
		end
		if (wr_td31) begin
			nxt_tdata[31:16] = reg_bus.wdata;
		end
		unique case (tstate_ff)
			TS_IDLE: begin
			end
			TS_WAIT: begin
				// Returned data beats a same-cycle software write so no answer is lost
				if (tbl_rsp.done) begin
					nxt_tdata  = tbl_rsp.rdata;
					nxt_tstate = TS_IDLE;
				end
			end
		endcase
		// A new read launched as the old one finishes keeps TS_WAIT, so busy stays set if it targets a polled table
		if (wr_tac) begin
			nxt_cmd.valid = 1'b1;
			nxt_cmd.rd    = reg_bus.wdata[TAC_DIR_BIT];
			nxt_cmd.sel   = dpt_sel_e'(reg_bus.wdata[TAC_SEL_LSB +: 2]);
			nxt_cmd.addr  = reg_bus.wdata[TA_W-1:0];
			nxt_cmd.wdata = tdata_ff;
			if (reg_bus.wdata[TAC_DIR_BIT]) begin
				nxt_tstate = TS_WAIT;
			end else begin
				nxt_tstate = TS_IDLE;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			tstate_ff  <= TS_IDLE;
			tdata_ff   <= TD_RST;
			tbl_cmd_ff <= '0;
		end else begin
			tstate_ff  <= nxt_tstate;
			tdata_ff   <= nxt_tdata;
			tbl_cmd_ff <= nxt_cmd;
		end
	end

	// Priority lookup; lower classes belong to maps outside this slice
	always_comb begin
		tos_idx        = pkt_in.tos[7:2];
		nxt_prio.valid = pkt_in.valid;
		nxt_prio.hit   = pkt_in.valid && tos_idx >= PRIO_BASE_IDX;
		nxt_prio.prio  = 2'h0;
		if (nxt_prio.hit) begin
			case (tos_idx[5:3])
				3'h5:    nxt_prio.prio = dpt_field(map6_ff, tos_idx[2:0]);
				3'h6:    nxt_prio.prio = dpt_field(map7_ff, tos_idx[2:0]);
				default: nxt_prio.prio = dpt_field(map8_ff, tos_idx[2:0]);
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			prio_ff <= '0;
		end else begin
			prio_ff <= nxt_prio;
		end
	end

	// Read mux; unmapped offsets and banks answer zero
	always_comb begin
		nxt_rdata = '0;
		if (reg_bus.rd) begin
			if (reg_bus.addr == OFF_BANK_SEL) begin
				nxt_rdata = {{(DATA_W-BANK_W){1'b0}}, bank_ff};
			end else begin
				case (bank_ff)
					BANK_PRIO_A: begin
						if (reg_bus.addr == OFF_MAP6) begin
							nxt_rdata = map6_ff;
						end
					end
					BANK_PRIO_B: begin
						if (reg_bus.addr == OFF_MAP7) begin
							nxt_rdata = map7_ff;
						end else if (reg_bus.addr == OFF_MAP8) begin
							nxt_rdata = map8_ff;
						end
					end
					BANK_TABLE: begin
						case (reg_bus.addr)
							OFF_TAC:    nxt_rdata = tac_ff;
							OFF_TD_TOP: nxt_rdata = {8'h00, busy, 4'h0, tdata_ff[66:64]};
							OFF_TD_47:  nxt_rdata = tdata_ff[47:32];
							OFF_TD_63:  nxt_rdata = tdata_ff[63:48];
							OFF_TD_15:  nxt_rdata = tdata_ff[15:0];
							OFF_TD_31:  nxt_rdata = tdata_ff[31:16];
							default:    nxt_rdata = '0;
						endcase
					end
					BANK_TEST: begin
						case (reg_bus.addr)
							OFF_DTC:       nxt_rdata = {8'h00, dtc_ff};
							OFF_ATC_LED:   nxt_rdata = {8'h00, led_current_ff, atc_rsvd_ff};
							OFF_ATC_SPARE: nxt_rdata = atc_spare_ff;
							default:       nxt_rdata = '0;
						endcase
					end
					default: nxt_rdata = '0;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			reg_rdata_ff <= '0;
		end else begin
			reg_rdata_ff <= nxt_rdata;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_tac_wr;
		reg_bus.wr && bank_ff == BANK_TABLE && reg_bus.addr == OFF_TAC;
	endsequence

	sequence s_poll_launch;
		s_tac_wr ##0 (reg_bus.wdata[TAC_DIR_BIT] && reg_bus.wdata[TAC_SEL_LSB + 1]);
	endsequence

	sequence s_map7_wr;
		reg_bus.wr && bank_ff == BANK_PRIO_B && reg_bus.addr == OFF_MAP7;
	endsequence

	chk_prio_map6: assert property (
		pkt_in.valid && pkt_in.tos[7:5] == 3'h5
		|=> prio_ff.hit && prio_ff.prio == $past(map6_ff[{pkt_in.tos[4:2], 1'b0} +: 2]))
		else $error("priority from map six wrong");

	chk_prio_low_miss: assert property (
		pkt_in.valid && pkt_in.tos[7:2] < PRIO_BASE_IDX |=> prio_ff.valid && !prio_ff.hit)
		else $error("class below slice reported as hit");

	chk_map7_readback: assert property (
		s_map7_wr ##1 (reg_bus.rd && bank_ff == BANK_PRIO_B && reg_bus.addr == OFF_MAP7
			&& !reg_bus.wr)
		|=> reg_rdata_ff == $past(reg_bus.wdata, 2))
		else $error("map seven readback mismatch");

	chk_map8_prio: assert property (
		pkt_in.valid && pkt_in.tos == 8'hfc |=> prio_ff.prio == $past(map8_ff[15:14]))
		else $error("class 0xfc not from map eight top field");

	chk_cmd_launch: assert property (
		s_tac_wr |=> tbl_cmd_ff.valid && tbl_cmd_ff.rd == $past(reg_bus.wdata[TAC_DIR_BIT])
			&& tbl_cmd_ff.addr == $past(reg_bus.wdata[TA_W-1:0])
			&& tbl_cmd_ff.sel == $past(reg_bus.wdata[TAC_SEL_LSB +: 2]))
		else $error("table command not launched as written");

	chk_cmd_pulse: assert property (
		tbl_cmd_ff.valid && !wr_tac |=> !tbl_cmd_ff.valid)
		else $error("table command valid longer than one cycle");

	chk_busy_set: assert property (
		s_poll_launch |=> busy ##1 (busy || $past(tbl_rsp.done)))
		else $error("busy bit not raised for polled read");

	chk_busy_clear: assert property (
		busy && tbl_rsp.done && !wr_tac
		|=> !busy && tdata_ff == $past(tbl_rsp.rdata))
		else $error("read completion not taken");

	chk_status_word: assert property (
		reg_bus.rd && bank_ff == BANK_TABLE && reg_bus.addr == OFF_TD_TOP
		|=> reg_rdata_ff == {8'h00, $past(busy), 4'h0, $past(tdata_ff[66:64])})
		else $error("status word wrong");

	chk_dtc_upper: assert property (
		reg_bus.rd && bank_ff == BANK_TEST && reg_bus.addr == OFF_DTC
		|=> reg_rdata_ff[15:8] == 8'h00 && reg_rdata_ff[7:0] == $past(dtc_ff))
		else $error("digital test control readback wrong");

	chk_rsvd_bank: assert property (
		reg_bus.rd && bank_ff == BANK_RSVD && reg_bus.addr != OFF_BANK_SEL
		|=> reg_rdata_ff == 16'h0000)
		else $error("reserved bank returned data");

	chk_led_drive: assert property (
		reg_bus.wr && bank_ff == BANK_TEST && reg_bus.addr == OFF_ATC_LED
		|=> led_current_ff == $past(reg_bus.wdata[7:6]))
		else $error("LED current select not updated");

	chk_status_zero: assert property (
		reg_bus.rd && bank_ff == BANK_TEST
			&& (reg_bus.addr == OFF_DTS || reg_bus.addr == OFF_ATS)
		|=> reg_rdata_ff == 16'h0000)
		else $error("test status register not zero");

endmodule

// file: sim/dpt_tbl_model.sv
// Behavioural table engine facing the command and response ports of the slice.
// Assumes one clock shared with the slice; read latency in cycles is set by lat.
module dpt_tbl_model
	import dpt_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	input  wire dpt_cmd_s   cmd,
	input  wire logic [3:0] lat,
	output dpt_rsp_s        rsp
);
	dpt_cmd_s   pend_ff;
	logic [4:0] cnt_ff;
	logic       busy_ff;

	// Data lines toggle outside done, so a late sample picks up garbage
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			busy_ff <= 1'b0;
			cnt_ff  <= 5'h0;
			rsp     <= '0;
			pend_ff <= '0;
		end else begin
			rsp.done  <= 1'b0;
			rsp.rdata <= ~rsp.rdata;
			if (cmd.valid && cmd.rd) begin
				pend_ff <= cmd;
				busy_ff <= 1'b1;
				cnt_ff  <= {1'b0, lat};
			end else if (busy_ff && cnt_ff != 5'h0) begin
				cnt_ff <= cnt_ff - 5'h1;
			end else if (busy_ff) begin
				busy_ff   <= 1'b0;
				rsp.done  <= 1'b1;
				rsp.rdata <= {pend_ff.sel, 1'b1, 64'hfedc_ba98_7654_3210 ^ {54'h0, pend_ff.addr}};
			end
		end
	end
endmodule

// file: sim/tb_dpt_regs.sv
// Self-checking bench for the banked priority, table access and test registers.
// Assumes the table engine model answers the command port; one 10 MHz clock.
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; \
	$display("FAIL %0t got %h exp %h", $time, (got), (exp)); end end

module tb_dpt_regs
	import dpt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic              core_clk = 1'b0;
	logic              reset_n;
	dpt_bus_s          reg_bus;
	logic [DATA_W-1:0] reg_rdata_ff;
	dpt_pkt_s          pkt_in;
	dpt_prio_s         prio_ff;
	dpt_cmd_s          tbl_cmd_ff;
	dpt_rsp_s          tbl_rsp;
	dpt_led_e          led_current_ff;
	logic [3:0]        lat;
	int                error_cnt = 0;
	int                samples_checked = 0;
	logic [15:0]       mp [3];
	logic [15:0]       got;
	logic [66:0]       exp_word;
	dpt_cmd_s          ec;
	logic [9:0]        a;
	int                k;
	int                s;
	int                n;

	always #50 core_clk = ~core_clk;

	dpt_regs dpt_regs_i (
		.core_clk       (core_clk),
		.reset_n        (reset_n),
		.reg_bus        (reg_bus),
		.reg_rdata_ff   (reg_rdata_ff),
		.pkt_in         (pkt_in),
		.prio_ff        (prio_ff),
		.tbl_cmd_ff     (tbl_cmd_ff),
		.tbl_rsp        (tbl_rsp),
		.led_current_ff (led_current_ff)
	);

	dpt_tbl_model dpt_tbl_model_i (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.cmd      (tbl_cmd_ff),
		.lat      (lat),
		.rsp      (tbl_rsp)
	);

	task automatic summarize();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic bus_wr(input logic [OFF_W-1:0] off, input logic [15:0] d);
		@(posedge core_clk);
		reg_bus <= '{wr: 1'b1, rd: 1'b0, addr: off, wdata: d};
		@(posedge core_clk);
		reg_bus <= '0;
	endtask

	task automatic bus_rd(input logic [OFF_W-1:0] off, output logic [15:0] d);
		@(posedge core_clk);
		reg_bus <= '{wr: 1'b0, rd: 1'b1, addr: off, wdata: 16'h0000};
		@(posedge core_clk);
		reg_bus <= '0;
		#1;
		d = reg_rdata_ff;
	endtask

	task automatic rd_chk(input logic [OFF_W-1:0] off, input logic [15:0] e);
		logic [15:0] d;
		bus_rd(off, d);
		`CHK(d, e)
	endtask

	task automatic at(input logic [5:0] bank);
		bus_wr(OFF_BANK_SEL, {10'h000, bank});
	endtask

	// Fields below class 0x a0 lie outside this slice and report no hit
	function automatic dpt_prio_s exp_prio(input int kk);
		dpt_prio_s p;
		p = '{valid: 1'b1, hit: 1'b0, prio: 2'h0};
		if (kk >= 40) begin
			p.hit = 1'b1;
			p.prio = 2'(mp[(kk - 40) / 8] >> (((kk - 40) % 8) * 2));
		end
		return p;
	endfunction

	initial begin
		repeat (20000) @(posedge core_clk);
		error_cnt++;
		summarize();
	end

	initial begin
		reg_bus = '0;
		pkt_in = '0;
		reset_n = 1'b0;
		lat = 4'h6;
		repeat (5) @(posedge core_clk);
		reset_n <= 1'b1;
		at(BANK_PRIO_A);
		rd_chk(OFF_MAP6, 16'h0000);
		at(BANK_PRIO_B);
		rd_chk(OFF_MAP7, 16'h0000);
		rd_chk(OFF_MAP8, 16'h0000);
		at(BANK_TABLE);
		rd_chk(OFF_TAC, 16'h0000);
		rd_chk(OFF_TD_TOP, 16'h0000);
		rd_chk(OFF_TD_47, 16'h0000);
		rd_chk(OFF_TD_63, 16'h0000);
		rd_chk(OFF_TD_15, 16'h0000);
		rd_chk(OFF_TD_31, 16'h0000);
		at(BANK_TEST);
		rd_chk(OFF_DTS, 16'h0000);
		rd_chk(OFF_ATS, 16'h0000);
		rd_chk(OFF_DTC, 16'h003f);
		rd_chk(OFF_ATC_LED, 16'h0000);
		rd_chk(OFF_ATC_SPARE, 16'h0000);
		`CHK(led_current_ff, LED_60MA)
		bus_wr(OFF_DTC, 16'hffa5);
		rd_chk(OFF_DTC, 16'h00a5);
		bus_wr(OFF_DTS, 16'hffff);
		bus_wr(OFF_ATS, 16'hffff);
		rd_chk(OFF_DTS, 16'h0000);
		rd_chk(OFF_ATS, 16'h0000);
		bus_wr(OFF_ATC_SPARE, 16'hbeef);
		rd_chk(OFF_ATC_SPARE, 16'hbeef);
		for (k = 0; k < 4; k++) begin
			bus_wr(OFF_ATC_LED, {8'hff, 2'(k), 6'h2a});
			@(posedge core_clk);
			#1;
			`CHK(led_current_ff, 2'(k))
			rd_chk(OFF_ATC_LED, {8'h00, 2'(k), 6'h2a});
		end
		bus_wr(OFF_BANK_SEL, 16'hffeb);
		rd_chk(OFF_BANK_SEL, 16'h002b);
		bus_wr(4'h0, 16'hffff);
		rd_chk(4'h0, 16'h0000);
		at(BANK_TABLE);
		rd_chk(4'hc, 16'h0000);
		mp = '{16'hb1e4, 16'h4e1b, 16'h27d8};
		at(BANK_PRIO_A);
		bus_wr(OFF_MAP6, mp[0]);
		rd_chk(OFF_MAP6, mp[0]);
		at(BANK_PRIO_B);
		bus_wr(OFF_MAP7, mp[1]);
		bus_wr(OFF_MAP8, mp[2]);
		rd_chk(OFF_MAP7, mp[1]);
		rd_chk(OFF_MAP8, mp[2]);
		// Low TOS bits carry junk to show only bits 7:2 select the field
		for (k = 0; k < 64; k++) begin
			@(posedge core_clk);
			pkt_in <= '{valid: 1'b1, tos: {6'(k), 2'(k + 1)}};
			@(posedge core_clk);
			pkt_in <= '0;
			#1;
			`CHK(prio_ff, exp_prio(k))
		end
		at(BANK_TABLE);
		bus_wr(OFF_TD_15, 16'h1111);
		bus_wr(OFF_TD_31, 16'h2222);
		bus_wr(OFF_TD_47, 16'h3333);
		bus_wr(OFF_TD_63, 16'h4444);
		bus_wr(OFF_TD_TOP, 16'hffff);
		rd_chk(OFF_TD_TOP, 16'h0000);
		rd_chk(OFF_TD_15, 16'h1111);
		rd_chk(OFF_TD_31, 16'h2222);
		rd_chk(OFF_TD_47, 16'h3333);
		rd_chk(OFF_TD_63, 16'h4444);
		for (s = 0; s < 4; s++) begin
			a = 10'(s * 129 + 3);
			ec = '{valid: 1'b1, rd: 1'b0, sel: dpt_sel_e'(s), addr: a,
				wdata: {3'h0, 16'h4444, 16'h3333, 16'h2222, 16'h1111}};
			bus_wr(OFF_TAC, {4'h0, 2'(s), a});
			#1;
			`CHK(tbl_cmd_ff, ec)
			@(posedge core_clk);
			#1;
			`CHK(tbl_cmd_ff.valid, 1'b0)
		end
		bus_wr(OFF_TAC, 16'he3ff);
		rd_chk(OFF_TAC, 16'he3ff);
		for (k = 0; k < 8; k++) begin
			s = k % 4;
			a = 10'(k * 97 + 5);
			lat = (k < 4) ? 4'h6 : 4'h1;
			exp_word = {2'(s), 1'b1, 64'hfedc_ba98_7654_3210 ^ {54'h0, a}};
			bus_wr(OFF_TAC, {3'h0, 1'b1, 2'(s), a});
			#1;
			`CHK({tbl_cmd_ff.rd, tbl_cmd_ff.sel, tbl_cmd_ff.addr}, {1'b1, 2'(s), a})
			bus_rd(OFF_TD_TOP, got);
			if (k < 4) begin
				`CHK(got[7], (s >= 2))
			end
			n = 0;
			while (got[7] === 1'b1 && n < 20) begin
				bus_rd(OFF_TD_TOP, got);
				n++;
			end
			`CHK(got[7], 1'b0)
			repeat (12) @(posedge core_clk);
			rd_chk(OFF_TD_TOP, {13'h0000, exp_word[66:64]});
			rd_chk(OFF_TD_15, exp_word[15:0]);
			rd_chk(OFF_TD_31, exp_word[31:16]);
			rd_chk(OFF_TD_47, exp_word[47:32]);
			rd_chk(OFF_TD_63, exp_word[63:48]);
		end
		bus_wr(OFF_TAC, 16'h0000);
		#1;
		`CHK(tbl_cmd_ff.wdata, exp_word)
		@(posedge core_clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		reset_n <= 1'b1;
		#1;
		`CHK(led_current_ff, LED_60MA)
		at(BANK_PRIO_A);
		rd_chk(OFF_MAP6, 16'h0000);
		summarize();
	end
endmodule
